// ==== core/fcl_consts.svh ====
// offsets, field positions, reset values and timing counts of the fuse and lock block
`ifndef FCL_CONSTS_SVH
`define FCL_CONSTS_SVH

// ---
// fuse byte offsets inside the fuse section
// ---
`define FCL_OFS_SYSCFG0     8'h05
`define FCL_OFS_SUPPLY      8'h06
`define FCL_OFS_CODE_LEN    8'h07
`define FCL_OFS_BOOT_LEN    8'h08
// lock word byte offset inside the lock section
`define FCL_OFS_LOCK_WORD   8'h00

// ---
// field positions
// ---
`define FCL_EEKEEP_BIT      0
`define FCL_SUPPLY_MSB      4
`define FCL_SUPPLY_LSB      3
`define FCL_DELAY_MSB       2
`define FCL_DELAY_LSB       0

// ---
// codes and values
// ---
`define FCL_SUPPLY_DUAL     2'h1
`define FCL_SUPPLY_SINGLE   2'h2
`define FCL_UNLOCK_KEY      32'h5cc5c55c
`define FCL_BLOCK_SHIFT     9
`define FCL_FUSE_RST        8'h00
`define FCL_KEY_RST         32'h00000000
`define FCL_RDATA_BLOCKED   8'h00

// ---
// timing
// ---
`define FCL_CLK_NS          40
`define FCL_MS_NS           1000000
`define FCL_MS_CYCLES       (`FCL_MS_NS / `FCL_CLK_NS)

`endif

// ==== core/fcl_pkg.sv ====
// types shared by the fuse configuration and debug lock block
package fcl_pkg;

    // memory sections as seen by the debug port and the cpu
    typedef enum logic [2:0] {
        FCL_SEC_FLASH   = 3'h0,
        FCL_SEC_SRAM    = 3'h1,
        FCL_SEC_EEPROM  = 3'h2,
        FCL_SEC_SIG     = 3'h3,
        FCL_SEC_USER    = 3'h4,
        FCL_SEC_FUSE    = 3'h5,
        FCL_SEC_LOCK    = 3'h6,
        FCL_SEC_REGS    = 3'h7
    } fcl_section_t;

    // full device erase sequence
    typedef enum logic [1:0] {
        FCL_ER_IDLE   = 2'h0,
        FCL_ER_FLASH  = 2'h1,
        FCL_ER_EEPROM = 2'h2,
        FCL_ER_KEY    = 2'h3
    } fcl_erase_state_t;

endpackage

// ==== core/fcl_powerup_timer.sv ====
// power-up delay counter: waits 0 to 64 ms before code may run
`timescale 1ns/1ps
`include "fcl_consts.svh"
module fcl_powerup_timer
    import fcl_pkg::*;
#(
    parameter int MS_CYCLES = `FCL_MS_CYCLES
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // control
    input  wire logic       start,
    input  wire logic [2:0] power_up_delay_select,
    // status
    output logic            delay_done
);
    localparam int CW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

    initial begin
        if (MS_CYCLES < 1) begin
            $error("MS_CYCLES below 1");
        end
    end

    logic [CW-1:0] cyc_reg;
    logic [6:0]    ms_reg;
    logic [6:0]    target_ms;

    // [R3] delay code to ms
    always_comb begin
        if (power_up_delay_select == 3'h0) begin
            target_ms = 7'h00;
        end else begin
            target_ms = 7'h01 << (power_up_delay_select - 3'h1);
        end
    end

    assign delay_done = start && (ms_reg == target_ms);

    // millisecond prescaler and ms counter
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cyc_reg <= '0;
            ms_reg  <= 7'h00;
        end else if (!start) begin
            cyc_reg <= '0;
            ms_reg  <= 7'h00;
        end else if (!delay_done) begin
            if (cyc_reg == CW'(MS_CYCLES - 1)) begin
                cyc_reg <= '0;
                ms_reg  <= ms_reg + 7'h01;
            end else begin
                cyc_reg <= cyc_reg + CW'(1);
            end
        end
    end
endmodule

// ==== core/fcl_section_map.sv ====
// boot and code section bounds from the size fuses, in bytes
`timescale 1ns/1ps
`include "fcl_consts.svh"
module fcl_section_map
    import fcl_pkg::*;
#(
    parameter int FLASH_BYTES = 65536,
    parameter int ADDR_W      = 18
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // fuse fields
    input  wire logic [7:0]        code_section_length,
    input  wire logic [7:0]        boot_section_length,
    // section bounds
    output logic [ADDR_W-1:0]      boot_end,
    output logic [ADDR_W-1:0]      code_end,
    output logic                   boot_all_flash
);
    initial begin
        if (FLASH_BYTES < 1 || FLASH_BYTES >= (2 ** ADDR_W) || ADDR_W < 17) begin
            $error("FLASH_BYTES too big");
        end
    end

    logic [ADDR_W-1:0] boot_bytes;
    logic [ADDR_W-1:0] code_bytes;

    // [R4] [R5] lengths in 512-byte blocks
    assign boot_bytes = ADDR_W'(boot_section_length) << `FCL_BLOCK_SHIFT;
    assign code_bytes = ADDR_W'(code_section_length) << `FCL_BLOCK_SHIFT;

    // registered bounds
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            boot_end       <= '0;
            code_end       <= '0;
            boot_all_flash <= 1'b0;
        end else begin
            // [R6] zero boot length means all boot
            if (boot_section_length == 8'h00) begin
                boot_end       <= ADDR_W'(FLASH_BYTES);
                code_end       <= ADDR_W'(FLASH_BYTES);
                boot_all_flash <= 1'b1;
            end else begin
                boot_end       <= boot_bytes;
                code_end       <= code_bytes;
                boot_all_flash <= 1'b0;
            end
        end
    end
endmodule

// ==== core/fcl_lock_top.sv ====
// fuse configuration decode and debug port memory lock
//
// Operation
// [R1] keep fuse 0: full erase also erases eeprom.
// [R2] supply code 1 dual, 2 single, others reserved.
// [R3] delay code n gives 0 or 2^(n-1) ms.
// [R4] code length counts 512-byte blocks.
// [R5] boot length counts 512-byte blocks.
// [R6] boot length zero: whole flash is boot.
// [R7] only key 0x5cc5c55c unlocks.
// [R8] any other key written locks.
// [R9] locked: debug reads blocked.
// [R10] cpu access ignores the lock.
// [R11] unlocked: debug writes all but signature; cpu bars row, fuse, key writes.
// [R12] locked: only user row fuse-command writes pass.
// [R13] blocked reads ack with constant data.
// [R14] only full erase unlocks; user row kept.
// [R15] fuse registers reset to zero.
// [R16] lock follows current key combinationally.
`timescale 1ns/1ps
`include "fcl_consts.svh"
module fcl_lock_top
    import fcl_pkg::*;
#(
    parameter int FLASH_BYTES = 65536,
    parameter int ADDR_W      = 18,
    parameter int MS_CYCLES   = `FCL_MS_CYCLES
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    // nonvolatile fuse and key image
    input  wire logic [7:0]   nvm_syscfg0,
    input  wire logic [7:0]   nvm_supply_fuse,
    input  wire logic [7:0]   nvm_code_fuse,
    input  wire logic [7:0]   nvm_boot_fuse,
    input  wire logic [31:0]  nvm_key,
    // nonvolatile write back
    output logic              nvm_key_wr,
    output logic [31:0]       nvm_key_wdata,
    output logic              nvm_fuse_wr,
    output logic [7:0]        nvm_fuse_addr,
    output logic [7:0]        nvm_fuse_wdata,
    // single wire debug port access
    input  wire logic         dbg_req,
    input  wire logic         dbg_we,
    input  wire logic         dbg_fuse_cmd,
    input  wire fcl_section_t dbg_section,
    input  wire logic [15:0]  dbg_addr,
    input  wire logic [7:0]   dbg_wdata,
    input  wire logic         dbg_erase_req,
    output logic              dbg_granted,
    output logic              dbg_ack,
    output logic [7:0]        dbg_rdata,
    // memory strobes for debug accesses
    output logic              mem_dbg_rd,
    output logic              mem_dbg_wr,
    input  wire logic [7:0]   mem_rdata,
    // cpu access gate
    input  wire logic         cpu_req,
    input  wire logic         cpu_we,
    input  wire fcl_section_t cpu_section,
    output logic              cpu_grant,
    // full device erase
    output logic              erase_flash,
    output logic              erase_eeprom,
    input  wire logic         erase_done,
    output logic              erase_busy,
    // decoded configuration
    output logic              eeprom_keep_on_erase,
    output logic              supply_dual,
    output logic              supply_single,
    output logic              supply_reserved,
    output logic              boot_all_flash,
    output logic [ADDR_W-1:0] boot_end,
    output logic [ADDR_W-1:0] code_end,
    output logic              device_locked,
    output logic              cpu_run
);
    // ---
    // fuse capture
    // ---
    logic             fuse_valid_reg;
    logic             eekeep_reg;
    logic [7:0]       supply_and_startup_fuse_reg;
    logic [7:0]       code_section_length_fuse_reg;
    logic [7:0]       boot_section_length_fuse_reg;
    logic [31:0]      access_lock_word_reg;
    logic [31:0]      access_lock_word_next;
    logic             key_wr_hit;
    logic             key_erase_load;
    fcl_erase_state_t er_state_reg;
    fcl_erase_state_t er_state_next;

    // [R15] fuses load after release, reset to zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            fuse_valid_reg               <= 1'b0;
            eekeep_reg                   <= 1'b0;
            supply_and_startup_fuse_reg  <= `FCL_FUSE_RST;
            code_section_length_fuse_reg <= `FCL_FUSE_RST;
            boot_section_length_fuse_reg <= `FCL_FUSE_RST;
        end else if (!fuse_valid_reg) begin
            fuse_valid_reg               <= 1'b1;
            eekeep_reg                   <= nvm_syscfg0[`FCL_EEKEEP_BIT];
            supply_and_startup_fuse_reg  <= nvm_supply_fuse;
            code_section_length_fuse_reg <= nvm_code_fuse;
            boot_section_length_fuse_reg <= nvm_boot_fuse;
        end
    end

    // ---
    // configuration decode
    // ---
    logic [1:0] supply_scheme_select;
    logic [2:0] power_up_delay_select;
    logic       delay_done;

    assign supply_scheme_select  = supply_and_startup_fuse_reg[`FCL_SUPPLY_MSB:`FCL_SUPPLY_LSB];
    assign power_up_delay_select = supply_and_startup_fuse_reg[`FCL_DELAY_MSB:`FCL_DELAY_LSB];
    assign eeprom_keep_on_erase  = eekeep_reg;

    // [R2] supply scheme flags
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            supply_dual     <= 1'b0;
            supply_single   <= 1'b0;
            supply_reserved <= 1'b0;
        end else begin
            supply_dual     <= fuse_valid_reg && (supply_scheme_select == `FCL_SUPPLY_DUAL);
            supply_single   <= fuse_valid_reg && (supply_scheme_select == `FCL_SUPPLY_SINGLE);
            supply_reserved <= fuse_valid_reg && (supply_scheme_select != `FCL_SUPPLY_DUAL)
                               && (supply_scheme_select != `FCL_SUPPLY_SINGLE);
        end
    end

    // [R3] delay before code execution
    fcl_powerup_timer #(
        .MS_CYCLES             (MS_CYCLES)
    ) u_timer (
        .clk_sys               (clk_sys),
        .rstn                  (rstn),
        .start                 (fuse_valid_reg),
        .power_up_delay_select (power_up_delay_select),
        .delay_done            (delay_done)
    );

    // cpu run enable, sticky once delay elapsed
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cpu_run <= 1'b0;
        end else if (delay_done) begin
            cpu_run <= 1'b1;
        end
    end

    // [R4] [R5] [R6] section bounds
    fcl_section_map #(
        .FLASH_BYTES         (FLASH_BYTES),
        .ADDR_W              (ADDR_W)
    ) u_map (
        .clk_sys             (clk_sys),
        .rstn                (rstn),
        .code_section_length (code_section_length_fuse_reg),
        .boot_section_length (boot_section_length_fuse_reg),
        .boot_end            (boot_end),
        .code_end            (code_end),
        .boot_all_flash      (boot_all_flash)
    );

    // ---
    // lock decision and access gates
    // ---
    logic locked_now;
    logic dbg_rd_ok;
    logic dbg_wr_ok;
    logic dbg_open;

    // [R7] [R16] combinational key compare
    assign locked_now    = (access_lock_word_reg != `FCL_UNLOCK_KEY);
    assign device_locked = locked_now;
    assign dbg_open      = fuse_valid_reg && (er_state_reg == FCL_ER_IDLE);

    // [R9] [R12] locked reads blocked, user row too
    assign dbg_rd_ok = dbg_open && !locked_now;

    // [R11] [R12] debug write permission
    always_comb begin
        if (!dbg_open) begin
            dbg_wr_ok = 1'b0;
        end else if (!locked_now) begin
            dbg_wr_ok = (dbg_section != FCL_SEC_SIG);
        end else begin
            dbg_wr_ok = (dbg_section == FCL_SEC_USER) && dbg_fuse_cmd;
        end
    end

    assign dbg_granted = dbg_req && (dbg_we ? dbg_wr_ok : dbg_rd_ok);

    // strobes to the memories for sections held outside
    assign mem_dbg_rd = dbg_req && !dbg_we && dbg_rd_ok
                        && (dbg_section != FCL_SEC_FUSE) && (dbg_section != FCL_SEC_LOCK);
    assign mem_dbg_wr = dbg_req && dbg_we && dbg_wr_ok
                        && (dbg_section != FCL_SEC_FUSE) && (dbg_section != FCL_SEC_LOCK);

    // [R10] [R11] cpu gate ignores lock, bars signature row, fuse, key writes
    assign cpu_grant = cpu_req && (!cpu_we || ((cpu_section != FCL_SEC_SIG)
                       && (cpu_section != FCL_SEC_FUSE) && (cpu_section != FCL_SEC_LOCK)));

    // ---
    // debug read data
    // ---
    logic [7:0] int_rdata;

    // fuse and lock word bytes held here
    always_comb begin
        int_rdata = 8'h00;
        if (dbg_section == FCL_SEC_LOCK) begin
            int_rdata = access_lock_word_reg[{dbg_addr[1:0], 3'h0} +: 8];
        end else begin
            unique case (dbg_addr[7:0])
                `FCL_OFS_SYSCFG0:  int_rdata = {7'h00, eekeep_reg};
                `FCL_OFS_SUPPLY:   int_rdata = {3'h0, supply_and_startup_fuse_reg[4:0]};
                `FCL_OFS_CODE_LEN: int_rdata = code_section_length_fuse_reg;
                `FCL_OFS_BOOT_LEN: int_rdata = boot_section_length_fuse_reg;
                default:           int_rdata = 8'h00;
            endcase
        end
    end

    // [R13] every request acked, blocked reads give constant
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dbg_ack   <= 1'b0;
            dbg_rdata <= 8'h00;
        end else begin
            dbg_ack <= dbg_req;
            if (dbg_req && !dbg_we) begin
                if (!dbg_rd_ok) begin
                    dbg_rdata <= `FCL_RDATA_BLOCKED;
                end else if (dbg_section == FCL_SEC_FUSE || dbg_section == FCL_SEC_LOCK) begin
                    dbg_rdata <= int_rdata;
                end else begin
                    dbg_rdata <= mem_rdata;
                end
            end
        end
    end

    // ---
    // lock word and fuse write back
    // ---
    assign key_wr_hit     = dbg_req && dbg_we && dbg_wr_ok && (dbg_section == FCL_SEC_LOCK);
    assign key_erase_load = (er_state_reg == FCL_ER_KEY);

    // [R8] byte write of the lock word
    always_comb begin
        access_lock_word_next = access_lock_word_reg;
        if (key_erase_load) begin
            access_lock_word_next = `FCL_UNLOCK_KEY;
        end else if (key_wr_hit) begin
            access_lock_word_next[{dbg_addr[1:0], 3'h0} +: 8] = dbg_wdata;
        end
    end

    // key loads from nvm once, then follows writes and erase
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            access_lock_word_reg <= `FCL_KEY_RST;
        end else if (!fuse_valid_reg) begin
            access_lock_word_reg <= nvm_key;
        end else begin
            access_lock_word_reg <= access_lock_word_next;
        end
    end

    // key write back to nonvolatile store
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            nvm_key_wr    <= 1'b0;
            nvm_key_wdata <= 32'h00000000;
        end else begin
            nvm_key_wr <= fuse_valid_reg && (key_wr_hit || key_erase_load);
            if (fuse_valid_reg && (key_wr_hit || key_erase_load)) begin
                nvm_key_wdata <= access_lock_word_next;
            end
        end
    end

    // fuse write back, takes effect at next reset
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            nvm_fuse_wr    <= 1'b0;
            nvm_fuse_addr  <= 8'h00;
            nvm_fuse_wdata <= 8'h00;
        end else begin
            nvm_fuse_wr <= dbg_req && dbg_we && dbg_wr_ok && (dbg_section == FCL_SEC_FUSE);
            if (dbg_req && dbg_we && dbg_wr_ok && (dbg_section == FCL_SEC_FUSE)) begin
                nvm_fuse_addr  <= dbg_addr[7:0];
                nvm_fuse_wdata <= dbg_wdata;
            end
        end
    end

    // ---
    // full device erase
    // ---
    // [R14] [R1] flash, then eeprom unless kept, then unlock key
    always_comb begin
        er_state_next = er_state_reg;
        unique case (er_state_reg)
            FCL_ER_IDLE: begin
                if (dbg_erase_req && fuse_valid_reg) begin
                    er_state_next = FCL_ER_FLASH;
                end
            end
            FCL_ER_FLASH: begin
                if (erase_done) begin
                    er_state_next = eekeep_reg ? FCL_ER_KEY : FCL_ER_EEPROM;
                end
            end
            FCL_ER_EEPROM: begin
                if (erase_done) begin
                    er_state_next = FCL_ER_KEY;
                end
            end
            FCL_ER_KEY: begin
                er_state_next = FCL_ER_IDLE;
            end
        endcase
    end

    // erase sequencer state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            er_state_reg <= FCL_ER_IDLE;
        end else begin
            er_state_reg <= er_state_next;
        end
    end

    // erase strobes; user row never erased here
    assign erase_flash  = (er_state_reg == FCL_ER_FLASH);
    assign erase_eeprom = (er_state_reg == FCL_ER_EEPROM);
    assign erase_busy   = (er_state_reg != FCL_ER_IDLE);
endmodule

// ==== tb/fcl_lock_top_assertions.sv ====
// port-level checks of the fuse and debug lock block
`timescale 1ns/1ps
`include "fcl_consts.svh"
module fcl_lock_top_assertions
    import fcl_pkg::*;
(
    // clock and reset
    input wire logic         clk_sys,
    input wire logic         rstn,
    // debug port
    input wire logic         dbg_req,
    input wire logic         dbg_we,
    input wire logic         dbg_fuse_cmd,
    input wire fcl_section_t dbg_section,
    input wire logic         dbg_granted,
    input wire logic         dbg_ack,
    input wire logic [7:0]   dbg_rdata,
    // erase and lock state
    input wire logic         erase_flash,
    input wire logic         erase_eeprom,
    input wire logic         erase_done,
    input wire logic         erase_busy,
    input wire logic         eeprom_keep_on_erase,
    input wire logic         nvm_key_wr,
    input wire logic [31:0]  nvm_key_wdata,
    input wire logic         device_locked
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // erase steps
    sequence s_flash_done; erase_flash && erase_done; endsequence
    sequence s_erase_end; erase_busy ##1 !erase_busy; endsequence
    a_ack_every_req: assert property (dbg_ack == $past(dbg_req))
        else $error("ack not one cycle after request");
    a_locked_read_blk: assert property (device_locked && dbg_req && !dbg_we |-> !dbg_granted)
        else $error("locked read granted");
    a_locked_wr_gate: assert property (device_locked && dbg_req && dbg_we && !erase_busy
        |-> dbg_granted == (dbg_section == FCL_SEC_USER && dbg_fuse_cmd))
        else $error("locked write gate wrong");
    a_blocked_rd_zero: assert property (dbg_req && !dbg_we && !dbg_granted
        |=> dbg_rdata == `FCL_RDATA_BLOCKED)
        else $error("blocked read shows data");
    a_unlocked_access: assert property (!device_locked && dbg_req && !erase_busy
        |-> dbg_granted == (!dbg_we || dbg_section != FCL_SEC_SIG))
        else $error("unlocked access gate wrong");
    a_key_write_lock: assert property (nvm_key_wr
        |-> device_locked == (nvm_key_wdata != `FCL_UNLOCK_KEY))
        else $error("lock state does not follow key");
    a_eeprom_phase: assert property (s_flash_done |=> erase_eeprom == !eeprom_keep_on_erase)
        else $error("eeprom erase phase wrong");
    a_erase_unlocks: assert property (s_erase_end |-> !device_locked && nvm_key_wr)
        else $error("erase did not unlock");
endmodule

// ==== tb/fcl_nvm_model.sv ====
// memory and erase engine model behind the lock block
`timescale 1ns/1ps
module fcl_nvm_model (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // memory side
    input wire logic        mem_dbg_rd,
    input wire logic [15:0] dbg_addr,
    input wire logic        erase_flash,
    input wire logic        erase_eeprom,
    input wire logic [3:0]  erase_wait,
    output logic [7:0]      mem_rdata,
    output logic            erase_done
);
    logic [7:0] tick_reg;
    logic [3:0] wait_reg;
    // data only while read, else a pattern that moves every cycle
    assign mem_rdata = mem_dbg_rd ? (dbg_addr[7:0] ^ 8'h3c) : tick_reg;
    // erase_done comes erase_wait+1 cycles into each erase phase, prompt or slow
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_reg <= 8'h00;
            wait_reg <= 4'h0;
            erase_done <= 1'b0;
        end else begin
            tick_reg <= tick_reg + 8'h01;
            erase_done <= 1'b0;
            if ((erase_flash || erase_eeprom) && !erase_done) begin
                wait_reg <= wait_reg + 4'h1;
                if (wait_reg >= erase_wait) begin
                    erase_done <= 1'b1;
                    wait_reg <= 4'h0;
                end
            end
        end
    end
endmodule

// ==== tb/tb_fcl_lock_top.sv ====
// self-checking bench for the fuse and debug lock block
`timescale 1ns/1ps
`include "fcl_consts.svh"
module tb_fcl_lock_top;
    import fcl_pkg::*;
    localparam int FB = 65536;
    localparam int MS = 4;
    logic clk_sys, rstn, dbg_req, dbg_we, dbg_fuse_cmd, dbg_erase_req, cpu_req, cpu_we, erase_done, eep;
    logic [7:0] nvm_syscfg0, nvm_supply_fuse, nvm_code_fuse, nvm_boot_fuse, dbg_wdata, mem_rdata, dbg_rdata;
    logic [31:0] nvm_key, nvm_key_wdata;
    fcl_section_t dbg_section, cpu_section;
    logic [15:0] dbg_addr, a;
    logic [17:0] boot_end, code_end;
    logic [3:0] erase_wait;
    logic dbg_granted, dbg_ack, mem_dbg_rd, cpu_grant, erase_flash, erase_eeprom, erase_busy, nvm_key_wr;
    logic eeprom_keep_on_erase, supply_dual, supply_single, supply_reserved, device_locked, cpu_run;
    int err_count, checks_done, ms, rise_n;
    fcl_lock_top #(.FLASH_BYTES(FB), .ADDR_W(18), .MS_CYCLES(MS)) fcl_lock_top_inst (.clk_sys, .rstn,
        .nvm_syscfg0, .nvm_supply_fuse, .nvm_code_fuse, .nvm_boot_fuse, .nvm_key, .nvm_key_wr, .nvm_key_wdata,
        .nvm_fuse_wr(), .nvm_fuse_addr(), .nvm_fuse_wdata(), .dbg_req, .dbg_we, .dbg_fuse_cmd, .dbg_section,
        .dbg_addr, .dbg_wdata, .dbg_erase_req, .dbg_granted, .dbg_ack, .dbg_rdata, .mem_dbg_rd, .mem_dbg_wr(),
        .mem_rdata, .cpu_req, .cpu_we, .cpu_section, .cpu_grant, .erase_flash, .erase_eeprom, .erase_done,
        .erase_busy, .eeprom_keep_on_erase, .supply_dual, .supply_single, .supply_reserved,
        .boot_all_flash(), .boot_end, .code_end, .device_locked, .cpu_run);
    fcl_nvm_model fcl_nvm_model_inst (.clk_sys, .rstn, .mem_dbg_rd, .dbg_addr, .erase_flash, .erase_eeprom,
        .erase_wait, .mem_rdata, .erase_done);
    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // reset with new fuse image, then time the start-up delay
    task automatic boot_up(input logic [7:0] sup, input logic [31:0] key, input logic [7:0] bt, input logic kp);
        rstn = 0;
        {nvm_supply_fuse, nvm_key, nvm_boot_fuse, nvm_code_fuse} = {sup, key, bt, 8'($urandom)};
        nvm_syscfg0 = {7'($urandom), kp};
        repeat (12) @(posedge clk_sys);
        chk({supply_dual, supply_single, supply_reserved, cpu_run}, 0);
        #1 rstn = 1;
        for (rise_n = 0; rise_n < 400 && cpu_run !== 1'b1; rise_n++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask
    // one debug access, request left up for back-to-back use
    task automatic access(input fcl_section_t s, input logic we, fc, input logic [15:0] ad,
                          input logic [7:0] wd, input logic g, input logic [7:0] rd);
        dbg_section = s;
        {dbg_we, dbg_fuse_cmd, dbg_addr, dbg_wdata, dbg_req} = {we, fc, ad, wd, 1'b1};
        #5 chk(dbg_granted, g);
        @(posedge clk_sys);
        #1 chk(dbg_ack, 1);
        if (!we)
            chk(dbg_rdata, rd);
    endtask
    task automatic cpu_mix();
        for (int j = 0; j < 24; j++) begin
            {cpu_req, cpu_we} = 2'($urandom);
            cpu_section = fcl_section_t'(3'($urandom));
            #5 chk(cpu_grant, cpu_req && (!cpu_we || !(cpu_section inside {3, 5, 6})));
            @(posedge clk_sys);
            #1;
        end
        cpu_req = 0;
    endtask
    function automatic logic [7:0] exp_rd(int s, logic [15:0] ad);
        return (s == 5) ? nvm_boot_fuse : (s == 6) ? 8'h5c : ad[7:0] ^ 8'h3c;
    endfunction
    initial begin
        #(40 * 10000);
        err_count++;
        close_out();
    end
    initial begin
        void'($urandom(79771));
        {dbg_req, dbg_we, dbg_fuse_cmd, dbg_erase_req, cpu_req, cpu_we, dbg_addr, dbg_wdata} = '0;
        dbg_section = FCL_SEC_FLASH;
        cpu_section = FCL_SEC_FLASH;
        erase_wait = 4'h1;
        for (int i = 0; i < 8; i++) begin
            boot_up({3'h0, i[1:0], i[2:0]}, i[0] ? `FCL_UNLOCK_KEY : $urandom | 1, (i == 4) ? 0 : $urandom, i[1]);
            ms = (i == 0) ? 0 : 1 << (i - 1);
            chk(rise_n >= ms * MS + 1 && rise_n <= ms * MS + 5, 1);
            chk({supply_dual, supply_single, supply_reserved}, (i % 4 == 1) ? 4 : (i % 4 == 2) ? 2 : 1);
            chk(code_end, (nvm_boot_fuse == 0) ? FB : nvm_code_fuse * 512);
            chk(boot_end, (nvm_boot_fuse == 0) ? FB : nvm_boot_fuse * 512);
            chk({eeprom_keep_on_erase, device_locked}, {i[1], !i[0]});
            access(FCL_SEC_FUSE, 0, 0, 16'h0007, 8'h00, i[0], i[0] ? nvm_code_fuse : 8'h00);
            dbg_req = 0;
        end
        $display("test 0 done");
        for (int k = 0; k < 2; k++) begin
            boot_up(8'h08, `FCL_UNLOCK_KEY, $urandom, k[0]);
            erase_wait = 4'($urandom_range(1, 15));
            cpu_mix();
            for (int s = 0; s < 8; s++) begin
                a = (s == 5) ? 16'h0008 : (s == 6) ? 16'h0000 : 16'($urandom);
                access(fcl_section_t'(s), 0, 0, a, 8'h00, 1, exp_rd(s, a));
                access(fcl_section_t'(s), 1, 0, a, (s == 6) ? 8'h5c : $urandom, s != 3, 8'h00);
            end
            access(FCL_SEC_LOCK, 1, 0, 16'h0000, 8'h01 | $urandom, 1, 8'h00);
            access(FCL_SEC_FLASH, 0, 0, 16'h0010, 8'h00, 0, 8'h00);
            chk(device_locked, 1);
            for (int s = 0; s < 8; s++) begin
                access(fcl_section_t'(s), 0, 0, 16'h0008, 8'h00, 0, 8'h00);
                access(fcl_section_t'(s), 1, k[0], 16'h0008, 8'h5c, k[0] && s == 4, 8'h00);
            end
            dbg_req = 0;
            cpu_mix();
            dbg_erase_req = 1;
            @(posedge clk_sys);
            #1 dbg_erase_req = 0;
            eep = 0;
            for (int n = 0; n < 100 && erase_busy === 1'b1; n++) begin
                eep |= erase_eeprom;
                @(posedge clk_sys);
                #1;
            end
            chk({eep, erase_busy, device_locked}, {!k[0], 2'b00});
            access(FCL_SEC_FLASH, 0, 0, 16'h0020, 8'h00, 1, 8'h1c);
            dbg_req = 0;
            $display("test %0d done", k + 1);
        end
        close_out();
    end
endmodule
bind fcl_lock_top fcl_lock_top_assertions chk_inst (.clk_sys, .rstn, .dbg_req, .dbg_we, .dbg_fuse_cmd,
    .dbg_section, .dbg_granted, .dbg_ack, .dbg_rdata, .erase_flash, .erase_eeprom, .erase_done, .erase_busy,
    .eeprom_keep_on_erase, .nvm_key_wr, .nvm_key_wdata, .device_locked);
